// *** src/eer_pkg.sv ***
// shared constants and types for the serial eeprom read slave
// assumes a single 25 MHz reference clock domain on the device side
package eer_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned LOAD_FIFO_DEPTH = 16;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] BIT_CNT_FIRST = 4'h1;
  localparam logic [ADDR_W-1:0] PTR_RST = 8'h00;
  localparam logic [ADDR_W-1:0] PTR_STEP = 8'h01;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  // control byte layout, msb first on the wire
  localparam int unsigned CTRL_CODE_HI = 7;
  localparam int unsigned CTRL_CODE_LO = 4;
  localparam int unsigned CTRL_SEL_HI = 3;
  localparam int unsigned CTRL_SEL_LO = 1;
  localparam int unsigned CTRL_RW_BIT = 0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } eer_load_word_t;

  typedef enum logic [7:0] {
    EER_IDLE = 8'h01,
    EER_CTRL = 8'h02,
    EER_CACK = 8'h04,
    EER_ADDR = 8'h08,
    EER_AACK = 8'h10,
    EER_TX = 8'h20,
    EER_RACK = 8'h40,
    EER_WAIT = 8'h80
  } eer_state_t;
endpackage : eer_pkg

// *** src/eer_read_slave.sv ***
// two-wire eeprom read slave with a buffered array load port
// assumes scl, sda and chip-select pins are asynchronous; master owns scl
`timescale 1ns/1ps

module eer_load_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ZERO = '0;
  localparam logic [AW-1:0] PTR_ONE = AW'(1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic [AW:0] nxt_cnt;
  logic in_ready_ff;
  logic push;
  logic pop;

  assign push = i_in_valid && in_ready_ff;
  assign pop = (cnt_ff != CNT_ZERO) && i_out_ready;
  assign o_in_ready = in_ready_ff;
  assign o_out_valid = (cnt_ff != CNT_ZERO);
  assign o_out_data = mem_ff[rd_ptr_ff];

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + (AW+1)'(1);
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - (AW+1)'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= CNT_ZERO;
      in_ready_ff <= 1'b1;
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      // registered full flag keeps the ready port glitch free
      in_ready_ff <= (nxt_cnt != CNT_FULL);
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + PTR_ONE;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= i_in_data;
    end
  end
endmodule : eer_load_fifo

module eer_read_slave #(
  // arbitrary device-type code, not a real part value
  parameter logic [3:0] DEV_CODE = 4'h5
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // two-wire bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // chip-select straps
  input wire logic i_chip_select_pin_high,
  input wire logic i_chip_select_pin_mid,
  input wire logic i_chip_select_pin_low,
  // internal programming cycle in progress
  input wire logic i_prog_busy,
  // array load stream
  input wire logic i_load_valid,
  input wire eer_pkg::eer_load_word_t i_load_word,
  output logic o_load_ready
);
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic [2:0] sel_sync0_ff;
  logic [2:0] sel_sync1_ff;
  logic busy_sync0_ff;
  logic busy_sync1_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic scl_q;
  logic sda_q;

  eer_pkg::eer_state_t state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic rw_ff;
  logic mst_ack_ff;
  logic [7:0] ptr_ff;
  logic sda_oe_ff;
  logic sda_out_ff;
  logic [7:0] mem_ff [eer_pkg::MEM_DEPTH];
  logic [7:0] rd_byte;
  logic ctrl_match;
  logic ld_valid;
  logic ld_ready;
  eer_pkg::eer_load_word_t ld_word;

  function automatic logic [7:0] ptr_next(input logic [7:0] p);
    // plain 8-bit add rolls the top location over to zero
    return p + eer_pkg::PTR_STEP;
  endfunction : ptr_next

  assign rst_n = rst_sync_ff[1];
  assign scl_q = scl_sync_ff[1];
  assign sda_q = sda_sync_ff[1];
  assign scl_rise = scl_q && !scl_prev_ff;
  assign scl_fall = !scl_q && scl_prev_ff;
  assign start_det = scl_q && scl_prev_ff && sda_prev_ff && !sda_q;
  assign stop_det = scl_q && scl_prev_ff && !sda_prev_ff && sda_q;
  assign rd_byte = mem_ff[ptr_ff];
  assign o_sda_oe = sda_oe_ff;
  assign o_sda_out = sda_out_ff;

  assign ctrl_match = (rx_ff[eer_pkg::CTRL_CODE_HI:eer_pkg::CTRL_CODE_LO] == DEV_CODE)
    && (rx_ff[eer_pkg::CTRL_SEL_HI:eer_pkg::CTRL_SEL_LO] == sel_sync1_ff);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      sel_sync0_ff <= 3'h0;
      sel_sync1_ff <= 3'h0;
      busy_sync0_ff <= 1'b0;
      busy_sync1_ff <= 1'b0;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], i_scl};
      sda_sync_ff <= {sda_sync_ff[0], i_sda};
      sel_sync0_ff <= {i_chip_select_pin_high, i_chip_select_pin_mid, i_chip_select_pin_low};
      sel_sync1_ff <= sel_sync0_ff;
      busy_sync0_ff <= i_prog_busy;
      busy_sync1_ff <= busy_sync0_ff;
      scl_prev_ff <= scl_q;
      sda_prev_ff <= sda_q;
    end
  end

  // bus protocol sequencer
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= eer_pkg::EER_IDLE;
      bit_cnt_ff <= eer_pkg::BIT_CNT_RST;
      rx_ff <= eer_pkg::BYTE_RST;
      tx_ff <= eer_pkg::BYTE_RST;
      rw_ff <= 1'b0;
      mst_ack_ff <= 1'b0;
      ptr_ff <= eer_pkg::PTR_RST;
      sda_oe_ff <= 1'b0;
      sda_out_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= eer_pkg::EER_IDLE;
      sda_oe_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= eer_pkg::EER_CTRL;
      bit_cnt_ff <= eer_pkg::BIT_CNT_RST;
      sda_oe_ff <= 1'b0;
    end else begin
      case (state_ff)
        eer_pkg::EER_CTRL, eer_pkg::EER_ADDR: begin
          if (scl_rise && bit_cnt_ff != eer_pkg::BITS_PER_BYTE) begin
            rx_ff <= {rx_ff[6:0], sda_q};
            bit_cnt_ff <= bit_cnt_ff + eer_pkg::BIT_CNT_FIRST;
          end else if (scl_fall && bit_cnt_ff == eer_pkg::BITS_PER_BYTE) begin
            bit_cnt_ff <= eer_pkg::BIT_CNT_RST;
            if (state_ff == eer_pkg::EER_ADDR) begin
              ptr_ff <= rx_ff;
              sda_oe_ff <= 1'b1;
              state_ff <= eer_pkg::EER_AACK;
            end else if (ctrl_match && !busy_sync1_ff) begin
              rw_ff <= rx_ff[eer_pkg::CTRL_RW_BIT];
              sda_oe_ff <= 1'b1;
              state_ff <= eer_pkg::EER_CACK;
            end else begin
              state_ff <= eer_pkg::EER_WAIT;
            end
          end
        end
        eer_pkg::EER_CACK: begin
          if (scl_fall) begin
            if (rw_ff) begin
              // first bit of byte at pointer
              tx_ff <= {rd_byte[6:0], 1'b0};
              sda_oe_ff <= !rd_byte[7];
              bit_cnt_ff <= eer_pkg::BIT_CNT_FIRST;
              state_ff <= eer_pkg::EER_TX;
            end else begin
              sda_oe_ff <= 1'b0;
              state_ff <= eer_pkg::EER_ADDR;
            end
          end
        end
        eer_pkg::EER_AACK: begin
          if (scl_fall) begin
            // data bytes belong to the write path
            sda_oe_ff <= 1'b0;
            state_ff <= eer_pkg::EER_WAIT;
          end
        end
        eer_pkg::EER_TX: begin
          if (scl_fall) begin
            if (bit_cnt_ff == eer_pkg::BITS_PER_BYTE) begin
              sda_oe_ff <= 1'b0;
              ptr_ff <= ptr_next(ptr_ff);
              state_ff <= eer_pkg::EER_RACK;
            end else begin
              sda_oe_ff <= !tx_ff[7];
              tx_ff <= {tx_ff[6:0], 1'b0};
              bit_cnt_ff <= bit_cnt_ff + eer_pkg::BIT_CNT_FIRST;
            end
          end
        end
        eer_pkg::EER_RACK: begin
          if (scl_rise) begin
            mst_ack_ff <= !sda_q;
          end else if (scl_fall) begin
            if (mst_ack_ff) begin
              tx_ff <= {rd_byte[6:0], 1'b0};
              sda_oe_ff <= !rd_byte[7];
              bit_cnt_ff <= eer_pkg::BIT_CNT_FIRST;
              state_ff <= eer_pkg::EER_TX;
            end else begin
              sda_oe_ff <= 1'b0;
              state_ff <= eer_pkg::EER_IDLE;
            end
          end
        end
        eer_pkg::EER_IDLE, eer_pkg::EER_WAIT: begin
          sda_oe_ff <= 1'b0;
        end
        default: begin
          state_ff <= eer_pkg::EER_IDLE;
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // array loads only between transactions so a read never races a write
  assign ld_ready = (state_ff == eer_pkg::EER_IDLE);

  always_ff @(posedge i_ref_clk) begin
    if (ld_valid && ld_ready) begin
      mem_ff[ld_word.addr] <= ld_word.data;
    end
  end

  eer_load_fifo #(
    .WIDTH($bits(eer_pkg::eer_load_word_t)),
    .DEPTH(eer_pkg::LOAD_FIFO_DEPTH)
  ) u_load_fifo (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_in_valid(i_load_valid),
    .i_in_data(i_load_word),
    .o_in_ready(o_load_ready),
    .o_out_valid(ld_valid),
    .o_out_data(ld_word),
    .i_out_ready(ld_ready)
  );
endmodule : eer_read_slave

// *** testbench/eer_bus_master.sv ***
// two-wire bus master model: scl and the master side of sda
// assumes an open-drain sda with a pull-up in the bench
`timescale 1ns/1ps
module eer_bus_master (
  // clock
  input wire logic i_clk,
  // bus lines
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wt
  task automatic bit_io(input logic v, output logic s);
    wt(2);
    o_sda <= v;
    // scl low 5 clocks, high 3: one 320 ns bit
    wt(3);
    o_scl <= 1'b1;
    wt(1);
    @(negedge i_clk);
    s = i_sda;
    wt(2);
    o_scl <= 1'b0;
  endtask : bit_io
  task automatic start();
    wt(2);
    o_sda <= 1'b1;
    wt(2);
    o_scl <= 1'b1;
    wt(4);
    o_sda <= 1'b0;
    wt(4);
    o_scl <= 1'b0;
  endtask : start
  task automatic stop();
    wt(2);
    o_sda <= 1'b0;
    wt(2);
    o_scl <= 1'b1;
    wt(4);
    o_sda <= 1'b1;
    wt(16);
  endtask : stop
  task automatic wr_byte(input logic [7:0] b, output logic a);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], x);
    end
    bit_io(1'b1, a);
  endtask : wr_byte
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(nack, x);
  endtask : rd_byte
endmodule : eer_bus_master

// *** testbench/eer_read_slave_asserts.sv ***
// pin-level checker for the eeprom read slave
// bound to every eer_read_slave instance
`timescale 1ns/1ps
module eer_read_slave_asserts #(
  parameter logic [3:0] DEV_CODE = 4'h5
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_chip_select_pin_high,
  input wire logic i_chip_select_pin_mid,
  input wire logic i_chip_select_pin_low,
  input wire logic i_prog_busy,
  input wire logic i_load_valid,
  input wire eer_pkg::eer_load_word_t i_load_word,
  input wire logic o_load_ready
);
  logic scl_ff;
  logic sda_ff;
  logic [3:0] bit_ff;
  logic [7:0] shift_ff;
  logic [4:0] high_ff;
  logic last_fall;
  logic match;
  logic stop;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  assign last_fall = scl_ff & ~i_scl & (bit_ff == 4'h8);
  assign stop = scl_ff & i_scl & ~sda_ff & i_sda;
  assign match = shift_ff[7:1] == {DEV_CODE, i_chip_select_pin_high,
    i_chip_select_pin_mid, i_chip_select_pin_low};
  // first byte after a start only; idle at 9
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      bit_ff <= 4'h9;
      shift_ff <= 8'h00;
      high_ff <= 5'h00;
    end else begin
      scl_ff <= i_scl;
      sda_ff <= i_sda;
      high_ff <= !i_scl ? 5'h00 : (high_ff == 5'h1f ? high_ff : high_ff + 5'h01);
      if (scl_ff && i_scl && sda_ff && !i_sda) begin
        bit_ff <= 4'h0;
      end else if (!scl_ff && i_scl && bit_ff < 4'h9) begin
        bit_ff <= bit_ff + 4'h1;
        shift_ff <= {shift_ff[6:0], i_sda};
      end
    end
  end
  a_sda_out_zero: assert property (o_sda_out == 1'b0)
    else $error("sda output value not low");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("sda drive changed while scl high");
  a_ctrl_ack: assert property (last_fall && match && !i_prog_busy |-> ##[1:5] o_sda_oe)
    else $error("matching control byte not acknowledged");
  a_ctrl_refuse: assert property (last_fall && !match |-> !o_sda_oe [*6])
    else $error("foreign control byte acknowledged");
  a_busy_silent: assert property (last_fall && i_prog_busy && $past(i_prog_busy, 8)
    |-> !o_sda_oe [*6])
    else $error("acknowledge during programming");
  a_stop_quiet: assert property (stop |-> !o_sda_oe [*8])
    else $error("sda driven after stop");
  a_idle_release: assert property (high_ff > 5'h0c |-> !o_sda_oe)
    else $error("sda held while bus idle");
  a_ready_on_push: assert property ($fell(o_load_ready) |-> $past(i_load_valid))
    else $error("load ready fell without a push");
endmodule : eer_read_slave_asserts

bind eer_read_slave eer_read_slave_asserts #(.DEV_CODE(DEV_CODE)) i_eer_read_slave_asserts (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .i_chip_select_pin_high(i_chip_select_pin_high), .i_chip_select_pin_mid(i_chip_select_pin_mid),
  .i_chip_select_pin_low(i_chip_select_pin_low), .i_prog_busy(i_prog_busy),
  .i_load_valid(i_load_valid), .i_load_word(i_load_word), .o_load_ready(o_load_ready));

// *** testbench/eer_read_slave_tb.sv ***
// self-checking bench for the eeprom read slave
// assumes the bus master model and the bound pin checker
`timescale 1ns/1ps
module eer_read_slave_tb;
  // arbitrary device-type code
  localparam logic [3:0] CODE = 4'h5;
  logic clk;
  logic rst_n;
  logic [2:0] sel;
  logic busy;
  logic load_valid;
  eer_pkg::eer_load_word_t load_word;
  logic load_ready;
  logic scl;
  logic m_sda;
  logic sda_oe;
  logic sda_out;
  logic sda;
  int fail_count;
  int checked;
  assign sda = m_sda & (~sda_oe | sda_out);
  eer_read_slave #(.DEV_CODE(CODE)) i_eer_read_slave (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_chip_select_pin_high(sel[2]), .i_chip_select_pin_mid(sel[1]),
    .i_chip_select_pin_low(sel[0]), .i_prog_busy(busy), .i_load_valid(load_valid),
    .i_load_word(load_word), .o_load_ready(load_ready));
  eer_bus_master i_eer_bus_master (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction : pat
  function automatic logic [7:0] ctl(input logic rd);
    return {CODE, sel, rd};
  endfunction : ctl
  task automatic set_ptr(input logic [7:0] a);
    logic k;
    i_eer_bus_master.start();
    i_eer_bus_master.wr_byte(ctl(1'b0), k);
    chk("write ctrl ack", k, 1'b0);
    i_eer_bus_master.wr_byte(a, k);
    chk("word addr ack", k, 1'b0);
    i_eer_bus_master.start();
    i_eer_bus_master.wr_byte(ctl(1'b1), k);
    chk("read ctrl ack", k, 1'b0);
  endtask : set_ptr
  // bus held busy so the fifo cannot drain
  task automatic t_fill();
    logic k;
    logic [7:0] n;
    n = 8'h00;
    i_eer_bus_master.start();
    i_eer_bus_master.wr_byte(ctl(1'b0), k);
    repeat (20) begin
      @(posedge clk);
      load_valid <= 1'b1;
      load_word <= {8'hf8 + n, pat(8'hf8 + n)};
      @(negedge clk);
      if (load_ready === 1'b1) n++;
    end
    @(posedge clk);
    load_valid <= 1'b0;
    @(negedge clk);
    chk("fifo accepted", n, 8'h10);
    chk("fifo full", load_ready, 1'b0);
    i_eer_bus_master.stop();
    i_eer_bus_master.wt(60);
    chk("fifo drained", load_ready, 1'b1);
    $display("test fill done");
  endtask : t_fill
  task automatic t_rand();
    logic [7:0] d;
    logic k;
    set_ptr(8'h03);
    i_eer_bus_master.rd_byte(1'b1, d);
    chk("random byte", d, pat(8'h03));
    i_eer_bus_master.stop();
    i_eer_bus_master.start();
    i_eer_bus_master.wr_byte(ctl(1'b1), k);
    i_eer_bus_master.rd_byte(1'b1, d);
    chk("current byte", d, pat(8'h04));
    i_eer_bus_master.stop();
    $display("test random done");
  endtask : t_rand
  task automatic t_seq();
    logic [7:0] d;
    logic [7:0] a;
    a = 8'hfe;
    set_ptr(a);
    repeat (4) begin
      i_eer_bus_master.rd_byte(a == 8'h01, d);
      chk("seq byte", d, pat(a));
      a++;
    end
    // clocks after a nack, no stop: line must stay released
    i_eer_bus_master.rd_byte(1'b1, d);
    chk("idle after nack", d, 8'hff);
    i_eer_bus_master.stop();
    $display("test sequential done");
  endtask : t_seq
  task automatic t_refuse();
    logic k;
    i_eer_bus_master.start();
    i_eer_bus_master.wr_byte({CODE, ~sel, 1'b1}, k);
    chk("foreign select", k, 1'b1);
    i_eer_bus_master.start();
    i_eer_bus_master.wr_byte({~CODE, sel, 1'b1}, k);
    chk("foreign code", k, 1'b1);
    i_eer_bus_master.stop();
    @(posedge clk);
    busy <= 1'b1;
    i_eer_bus_master.start();
    i_eer_bus_master.wr_byte(ctl(1'b1), k);
    chk("busy ack", k, 1'b1);
    i_eer_bus_master.stop();
    busy <= 1'b0;
    $display("test refuse done");
  endtask : t_refuse
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    sel = 3'h5;
    busy = 1'b0;
    load_valid = 1'b0;
    load_word = 16'h0000;
    fail_count = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    i_eer_bus_master.wt(8);
    t_fill();
    t_rand();
    t_seq();
    t_refuse();
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule : eer_read_slave_tb
